/* File: mac_host_status_interface.sv */
// Host control and status register bank of the Manchester MAC layer.
// Assumes line-side logic on the same clock reports events as pulses.
// Notes on behaviour
// - Frame end by code violation sets bit 0
// - Receive error sets bit 1
// - Bit 2 marks priority transmit buffer full
// - Bit 3 marks non-priority transmit buffer full
// - Transmission start sets bit 4
// - Error-free completed send sets bit 5
// - Transmit error sets bit 6
// - Backlog counter overflow sets bit 7
// - Collision in preamble or tail sets bit 8
// - Set operation sets masked flags
// - Clear operation clears masked flags
// - Host reads 24-bit status flag word
// - Three 32-bit buffer start addresses readable
// - Last received packet length readable, 24 bits
// - Last packet timestamp readable in halves
// - Free-running timestamp readable in halves
// - Last packet 8-bit datagram info readable
// - Enable activates receive, transmit and DMA channels; driver enable and clash sense only when set in REG_OPT
// - Disable deactivates whole channel group
// - Enable after disable restarts traffic
//
// Decided for this implementation: the address map and the plain strobed port.
module mac_host_status_interface
  import mac_host_pkg::*;
#(
  parameter logic [31:0] RX_BUF_START = mac_host_pkg::RX_BUF_RESET,
  parameter logic [31:0] TXP_BUF_START = mac_host_pkg::TXP_BUF_RESET,
  parameter logic [31:0] TXN_BUF_START = mac_host_pkg::TXN_BUF_RESET
)
(
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire mac_host_pkg::reg_req_t i_req,
  input wire mac_host_pkg::mac_evt_t i_evt,
  input wire mac_host_pkg::rx_desc_t i_rx_desc,
  output logic [mac_host_pkg::DATA_W-1:0] o_rdata,
  output mac_host_pkg::chan_en_t o_chan_en,
  output logic o_send_req,
  output logic [mac_host_pkg::FLAG_W-1:0] o_flags
);
  import mac_host_pkg::*;

  // ==========================================================
  // Decode
  function automatic logic hit(input reg_req_t r, input logic [7:0] a);
    hit = (r.addr == a);
  endfunction : hit

  logic wr_ctrl;
  logic wr_set;
  logic wr_clr;
  logic wr_send;
  logic wr_opt;
  assign wr_ctrl = i_req.wr && hit(i_req, REG_CTRL);
  assign wr_set = i_req.wr && hit(i_req, REG_FLAG_SET);
  assign wr_clr = i_req.wr && hit(i_req, REG_FLAG_CLR);
  assign wr_send = i_req.wr && hit(i_req, REG_SEND_REQ);
  assign wr_opt = i_req.wr && hit(i_req, REG_OPT);

  // ==========================================================
  // Channel group enable
  logic [1:0] opt;
  always_ff @(posedge i_clock)
  begin
    if (!i_nrst)
      opt <= 2'h0;
    else if (wr_opt)
      opt <= i_req.wdata[1:0];
  end

  logic grp_on;
  always_ff @(posedge i_clock)
  begin
    if (!i_nrst)
      grp_on <= 1'b0;
    else if (wr_ctrl && i_req.wdata[CTRL_ENABLE])
      grp_on <= 1'b1;
    else if (wr_ctrl && i_req.wdata[CTRL_DISABLE])
      grp_on <= 1'b0;
  end

  // Optional channels follow the group only when configured
  always_ff @(posedge i_clock)
  begin
    if (!i_nrst)
      o_chan_en <= '0;
    else
    begin
      o_chan_en.receive_channel <= grp_on;
      o_chan_en.transmit_channel <= grp_on;
      o_chan_en.dma_channel <= grp_on;
      o_chan_en.driver_enable_channel <= grp_on && opt[OPT_DRV];
      o_chan_en.clash_sense_channel <= grp_on && opt[OPT_CLASH];
    end
  end

  // ==========================================================
  // Status flags
  logic [FLAG_W-1:0] hw_set;
  logic [FLAG_W-1:0] hw_clr;
  logic [FLAG_W-1:0] next_flags;
  always_comb
  begin
    hw_set = '0;
    hw_clr = '0;
    hw_set[FL_RX_END] = i_evt.rx_end;
    hw_set[FL_RX_ERR] = i_evt.rx_err;
    hw_set[FL_TX_BEGIN] = i_evt.tx_begin;
    hw_set[FL_TX_DONE] = i_evt.tx_done;
    hw_set[FL_TX_ERR] = i_evt.tx_err;
    hw_set[FL_BACKLOG] = i_evt.backlog_ovf;
    hw_set[FL_CLASH] = i_evt.clash;
    // Buffer full is set by the host and dropped once sent
    hw_clr[FL_TXP_FULL] = i_evt.txp_sent;
    hw_clr[FL_TXN_FULL] = i_evt.txn_sent;
    next_flags = o_flags;
    if (wr_clr)
      next_flags = next_flags & ~i_req.wdata[FLAG_W-1:0];
    if (wr_set)
      next_flags = next_flags | i_req.wdata[FLAG_W-1:0];
    next_flags = next_flags & ~hw_clr;
    // Hardware set beats a host clear in the same cycle
    next_flags = next_flags | hw_set;
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_nrst)
      o_flags <= '0;
    else
      o_flags <= next_flags;
  end

  // Request pulse; ordering of buffer load and flag is host's duty
  always_ff @(posedge i_clock)
  begin
    if (!i_nrst)
      o_send_req <= 1'b0;
    else
      o_send_req <= wr_send && grp_on;
  end

  // ==========================================================
  // Timestamp and last packet capture
  logic [2*HALF_W-1:0] ts;
  always_ff @(posedge i_clock)
  begin
    if (!i_nrst)
      ts <= '0;
    else
      ts <= ts + 48'h1;
  end

  logic [2*HALF_W-1:0] rx_ts;
  logic [HALF_W-1:0] rx_len;
  logic [INFO_W-1:0] rx_info;
  always_ff @(posedge i_clock)
  begin
    if (!i_nrst)
    begin
      rx_ts <= '0;
      rx_len <= '0;
      rx_info <= '0;
    end
    else if (i_evt.rx_end)
    begin
      rx_ts <= ts;
      rx_len <= i_rx_desc.length;
      rx_info <= i_rx_desc.info;
    end
  end

  // ==========================================================
  // Read port; unmapped addresses read zero
  always_ff @(posedge i_clock)
  begin
    if (!i_nrst)
      o_rdata <= '0;
    else if (i_req.rd)
    begin
      case (i_req.addr)
        REG_CTRL: o_rdata <= {31'h0, grp_on};
        REG_FLAGS: o_rdata <= {8'h0, o_flags};
        REG_RX_BUF: o_rdata <= RX_BUF_START;
        REG_TXP_BUF: o_rdata <= TXP_BUF_START;
        REG_TXN_BUF: o_rdata <= TXN_BUF_START;
        REG_RX_LEN: o_rdata <= {8'h0, rx_len};
        REG_RX_TS_HI: o_rdata <= {8'h0, rx_ts[47:24]};
        REG_RX_TS_LO: o_rdata <= {8'h0, rx_ts[23:0]};
        REG_RX_INFO: o_rdata <= {24'h0, rx_info};
        REG_TS_HI: o_rdata <= {8'h0, ts[47:24]};
        REG_TS_LO: o_rdata <= {8'h0, ts[23:0]};
        REG_OPT: o_rdata <= {30'h0, opt};
        default: o_rdata <= 32'h0;
      endcase
    end
    else
      o_rdata <= 32'h0;
  end

endmodule : mac_host_status_interface

/* File: mac_host_pkg.sv */
// Package for the host status interface of the Manchester MAC layer.
// Assumes one system clock and a plain strobe register port.
package mac_host_pkg;

  // ==========================================================
  // Widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int FLAG_W = 24;
  localparam int HALF_W = 24;
  localparam int INFO_W = 8;

  // ==========================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_FLAGS = 8'h04;
  localparam logic [7:0] REG_FLAG_SET = 8'h08;
  localparam logic [7:0] REG_FLAG_CLR = 8'h0C;
  localparam logic [7:0] REG_SEND_REQ = 8'h10;
  localparam logic [7:0] REG_RX_BUF = 8'h14;
  localparam logic [7:0] REG_TXP_BUF = 8'h18;
  localparam logic [7:0] REG_TXN_BUF = 8'h1C;
  localparam logic [7:0] REG_RX_LEN = 8'h20;
  localparam logic [7:0] REG_RX_TS_HI = 8'h24;
  localparam logic [7:0] REG_RX_TS_LO = 8'h28;
  localparam logic [7:0] REG_RX_INFO = 8'h2C;
  localparam logic [7:0] REG_TS_HI = 8'h30;
  localparam logic [7:0] REG_TS_LO = 8'h34;
  localparam logic [7:0] REG_OPT = 8'h38;

  // ==========================================================
  // Control fields
  localparam int CTRL_ENABLE = 0;
  localparam int CTRL_DISABLE = 1;
  localparam int OPT_DRV = 0;
  localparam int OPT_CLASH = 1;

  // ==========================================================
  // Status flag bit positions
  localparam int FL_RX_END = 0;
  localparam int FL_RX_ERR = 1;
  localparam int FL_TXP_FULL = 2;
  localparam int FL_TXN_FULL = 3;
  localparam int FL_TX_BEGIN = 4;
  localparam int FL_TX_DONE = 5;
  localparam int FL_TX_ERR = 6;
  localparam int FL_BACKLOG = 7;
  localparam int FL_CLASH = 8;

  // ==========================================================
  // Reset values
  localparam logic [31:0] RX_BUF_RESET = 32'h0000_0000;
  localparam logic [31:0] TXP_BUF_RESET = 32'h0000_0100;
  localparam logic [31:0] TXN_BUF_RESET = 32'h0000_0200;

  // ==========================================================
  // Register bus request
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  // Hardware events from the line-side logic, one-cycle pulses
  typedef struct packed {
    logic rx_end;
    logic rx_err;
    logic txp_sent;
    logic txn_sent;
    logic tx_begin;
    logic tx_done;
    logic tx_err;
    logic backlog_ovf;
    logic clash;
  } mac_evt_t;

  // Descriptor of a received packet, valid with rx_end
  typedef struct packed {
    logic [23:0] length;
    logic [7:0] info;
  } rx_desc_t;

  // Channel enables driven to the line-side logic
  typedef struct packed {
    logic receive_channel;
    logic transmit_channel;
    logic dma_channel;
    logic driver_enable_channel;
    logic clash_sense_channel;
  } chan_en_t;

endpackage : mac_host_pkg

/* File: mac_host_sva.sv */
// Assertion checker for the host status register bank.
// Assumes it is bound onto the bank top and sees its ports only.
module mac_host_sva
  import mac_host_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire mac_host_pkg::reg_req_t i_req,
  input wire mac_host_pkg::mac_evt_t i_evt,
  input wire mac_host_pkg::rx_desc_t i_rx_desc,
  input wire logic [mac_host_pkg::DATA_W-1:0] o_rdata,
  input wire mac_host_pkg::chan_en_t o_chan_en,
  input wire logic o_send_req,
  input wire logic [mac_host_pkg::FLAG_W-1:0] o_flags
);
  // ==========================================================
  // Helpers
  wire [8:0] evt_map = {i_evt.clash, i_evt.backlog_ovf, i_evt.tx_err,
    i_evt.tx_done, i_evt.tx_begin, 2'b00, i_evt.rx_err, i_evt.rx_end};
  wire set_wr = i_req.wr && i_req.addr == REG_FLAG_SET;
  wire clr_wr = i_req.wr && i_req.addr == REG_FLAG_CLR;
  wire ctl_wr = i_req.wr && i_req.addr == REG_CTRL;
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_nrst);
  // ==========================================================
  // Properties
  evt_flags_a: assert property (1 |=>
    (o_flags[8:0] & $past(evt_map)) == $past(evt_map)) else $error("event");
  txp_sent_a: assert property (i_evt.txp_sent |=> !o_flags[2])
    else $error("prio full stays");
  txn_sent_a: assert property (i_evt.txn_sent |=> !o_flags[3])
    else $error("nonprio full stays");
  set_mask_a: assert property (set_wr && i_evt == '0 |=> o_flags ==
    ($past(o_flags) | $past(i_req.wdata[23:0])))
    else $error("set mask");
  clr_mask_a: assert property (clr_wr && i_evt == '0 |=> o_flags ==
    ($past(o_flags) & ~$past(i_req.wdata[23:0]))) else $error("clr mask");
  rdata_idle_a: assert property (!i_req.rd |=> o_rdata == '0)
    else $error("read data not idle");
  send_cause_a: assert property (o_send_req |-> $past(i_req.wr) &&
    $past(i_req.addr) == REG_SEND_REQ) else $error("stray send");
  group_on_a: assert property (ctl_wr && i_req.wdata[0] |-> ##2
    o_chan_en.receive_channel && o_chan_en.transmit_channel &&
    o_chan_en.dma_channel) else $error("group on");
  group_off_a: assert property (ctl_wr && i_req.wdata[1:0] == 2'b10
    |-> ##2 o_chan_en == '0) else $error("group off");
endmodule : mac_host_sva

/* File: testbench.sv */
// Self-checking bench for the host status register bank.
// Assumes the package and the bank are compiled first.
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import mac_host_pkg::*;
  // ==========================================================
  // Stimulus and observation
  logic i_clock = 1'b0;
  logic i_nrst = 1'b0;
  reg_req_t req = '0;
  mac_evt_t evt = '0;
  rx_desc_t desc = '0;
  logic [31:0] rdata;
  chan_en_t chan;
  logic send;
  logic [23:0] flags;
  logic [31:0] last;
  logic [31:0] t0;
  int err_total = 0;
  int checks_done = 0;
  int sends = 0;
  always #50 i_clock = ~i_clock;
  always @(posedge i_clock) if (send === 1'b1) sends <= sends + 1;
  mac_host_status_interface mac_host_status_interface_i (.i_clock,
    .i_nrst, .i_req(req), .i_evt(evt), .i_rx_desc(desc), .o_rdata(rdata),
    .o_chan_en(chan), .o_send_req(send), .o_flags(flags));
  // ==========================================================
  // Bus tasks
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clock);
    req <= '{a, d, 1'b1, 1'b0};
    @(posedge i_clock);
    req.wr <= 1'b0;
  endtask : wr
  task automatic get(input logic [7:0] a);
    @(posedge i_clock);
    req <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge i_clock);
    req.rd <= 1'b0;
    #1 last = rdata;
  endtask : get
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    get(a);
    cmp(last, exp);
  endtask : rd
  task automatic pulse(input mac_evt_t e);
    @(posedge i_clock);
    evt <= e;
    @(posedge i_clock);
    evt <= '0;
  endtask : pulse
  task automatic settle;
    repeat (2) @(posedge i_clock);
    #1;
  endtask : settle
  // ==========================================================
  // Scenarios
  task automatic test_events;
    int fl[7] = '{0, 1, 4, 5, 6, 7, 8};
    desc <= '{24'h00ABCD, 8'h5A};
    foreach (fl[k])
    begin
      pulse(mac_evt_t'(9'h001 << (8 - fl[k])));
      rd(REG_FLAGS, 32'h1 << fl[k]);
      wr(REG_FLAG_CLR, 32'h1 << fl[k]);
      rd(REG_FLAGS, 32'h0);
    end
    rd(REG_RX_LEN, 32'h0000ABCD);
    rd(REG_RX_INFO, 32'h0000005A);
    get(REG_TS_LO);
    t0 = last;
    rd(REG_TS_LO, t0 + 32'h2);
    rd(REG_TS_HI, 32'h0);
    rd(REG_RX_TS_HI, 32'h0);
    $display("test events done");
  endtask : test_events
  task automatic test_buffers;
    wr(REG_FLAG_SET, 32'h0000000C);
    rd(REG_FLAGS, 32'h0000000C);
    cmp(32'(flags), 32'h0000000C);
    pulse('{txp_sent: 1'b1, default: 1'b0});
    rd(REG_FLAGS, 32'h00000008);
    pulse('{txn_sent: 1'b1, default: 1'b0});
    rd(REG_FLAGS, 32'h0);
    $display("test buffers done");
  endtask : test_buffers
  task automatic test_group;
    rd(REG_TXP_BUF, 32'h00000100);
    rd(REG_TXN_BUF, 32'h00000200);
    rd(REG_RX_BUF, 32'h0);
    rd(8'h3C, 32'h0);
    wr(REG_CTRL, 32'h1);
    settle();
    cmp(32'(chan), 32'h1C);
    wr(REG_OPT, 32'h3);
    settle();
    cmp(32'(chan), 32'h1F);
    wr(REG_FLAG_SET, 32'h00000004);
    wr(REG_SEND_REQ, 32'h0);
    pulse('{txp_sent: 1'b1, default: 1'b0});
    settle();
    cmp(32'(flags), 32'h0);
    wr(REG_CTRL, 32'h2);
    settle();
    cmp(32'(chan), 32'h0);
    wr(REG_SEND_REQ, 32'h0);
    wr(REG_CTRL, 32'h1);
    settle();
    cmp(32'(chan), 32'h1F);
    wr(REG_SEND_REQ, 32'h0);
    settle();
    cmp(32'(sends), 32'h2);
    $display("test group done");
  endtask : test_group
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish
  initial
  begin
    repeat (20) @(posedge i_clock);
    i_nrst <= 1'b1;
    test_group();
    test_events();
    test_buffers();
    tally_and_finish();
  end
  initial
  begin
    repeat (3000) @(posedge i_clock);
    err_total++;
    tally_and_finish();
  end
endmodule : testbench
bind mac_host_status_interface mac_host_sva mac_host_sva_i (.i_clock,
  .i_nrst, .i_req, .i_evt, .i_rx_desc, .o_rdata, .o_chan_en, .o_send_req,
  .o_flags);
